// File: hw/hpps_pin_select.sv
// Purpose: Host port pin selection between SPI and I2C, plus side pins
// Assumes: Selector and address straps are static while running
// Notes: Link logic runs on the shared serial clock pin
`timescale 1ns/100ps
module hpps_pin_select #(
  parameter int GPIO_N = hpps_pkg::GPIO_N,
  parameter int BYTE_W = hpps_pkg::BYTE_W
) (
  // Clocks and reset
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic link_clk,
  // Host bus pins
  input wire logic host_spi_sel_pin,
  input wire logic sclk_scl_pin,
  input wire logic select_or_addr_low_pin,
  input wire logic data_in_or_addr_high_pin,
  input wire logic dout_sda_in,
  output logic dout_sda_o_q,
  output logic dout_sda_oe_n_q,
  // Interrupt pin
  input wire logic irq_pending,
  output logic irq_o_q,
  output logic irq_oe_n_q,
  // Oscillator and PLL control
  output logic osc_pll_run_q,
  // General-purpose pins
  input wire hpps_pkg::hpps_gpio_mode_t [GPIO_N-1:0] gpio_mode,
  input wire logic [GPIO_N-1:0] gpio_out_val,
  input wire logic [GPIO_N-1:0] gpio_pin_in,
  output logic [GPIO_N-1:0] gpio_pin_o_q,
  output logic [GPIO_N-1:0] gpio_pin_oe_n_q,
  output logic [GPIO_N-1:0] gpio_in_q,
  // UART flow control pins
  input wire logic clear_send_n_pin,
  output logic cts_active_q,
  input wire logic [BYTE_W-1:0] line_control_register,
  output logic request_send_output_n_q,
  // Mode and straps
  output logic mode_spi_q,
  output logic [1:0] i2c_addr_q,
  // SPI core side
  input wire logic [BYTE_W-1:0] spi_tx_byte,
  output logic spi_cs_active_q,
  output logic [BYTE_W-1:0] spi_rx_byte_q,
  output logic spi_rx_valid_q,
  // I2C core side
  input wire logic i2c_sda_low,
  output logic i2c_scl_q,
  output logic i2c_sda_q
);

  // Synchronised pin levels
  logic [hpps_pkg::SY_N-1:0] sy_pin;
  logic [hpps_pkg::SY_N-1:0] sy_lvl;

  // Link domain, cleared by the frame's own select
  logic [2:0] lk_cnt_q;
  logic [2:0] lk_cnt_d;
  logic [BYTE_W-1:0] lk_rx_q;
  logic [BYTE_W-1:0] lk_rx_d;
  logic [BYTE_W-1:0] lk_tx_q;
  logic [BYTE_W-1:0] lk_tx_d;
  logic lk_dout_d;

  // Link domain, kept across frames
  logic [BYTE_W-1:0] lk_byte_q;
  logic [BYTE_W-1:0] lk_byte_d;
  logic lk_tog_q;
  logic lk_tog_d;

  // Core domain
  hpps_pkg::hpps_state_t st_q;
  hpps_pkg::hpps_state_t st_d;
  logic [2:0] wait_q;
  logic [2:0] wait_d;
  logic mode_spi_d;
  logic [1:0] i2c_addr_d;
  logic ack_q;
  logic ack_d;
  logic [BYTE_W-1:0] tx_hold_q;
  logic [BYTE_W-1:0] tx_hold_d;
  logic [BYTE_W-1:0] spi_rx_byte_d;
  logic spi_rx_valid_d;
  logic spi_cs_active_d;
  logic dout_sda_oe_n_d;
  logic irq_oe_n_d;
  logic osc_pll_run_d;
  logic cts_active_d;
  logic rts_n_d;
  logic i2c_scl_d;
  logic i2c_sda_d;
  logic running;

  assign sy_pin[hpps_pkg::SY_SEL] = host_spi_sel_pin;
  assign sy_pin[hpps_pkg::SY_CS] = select_or_addr_low_pin;
  assign sy_pin[hpps_pkg::SY_DIN] = data_in_or_addr_high_pin;
  assign sy_pin[hpps_pkg::SY_SCL] = sclk_scl_pin;
  assign sy_pin[hpps_pkg::SY_SDA] = dout_sda_in;
  assign sy_pin[hpps_pkg::SY_CTS] = clear_send_n_pin;
  assign sy_pin[hpps_pkg::SY_TOG] = lk_tog_q;

  genvar gi;
  generate
    for (gi = 0; gi < hpps_pkg::SY_N; gi++) begin : g_sync
      hpps_sync #(
        .RST_VAL(hpps_pkg::SY_RST[gi])
      ) u_sync (
        .clk(core_clk),
        .rst_b(rst_b),
        .pin(sy_pin[gi]),
        .level_q(sy_lvl[gi])
      );
    end
    for (gi = 0; gi < GPIO_N; gi++) begin : g_gpio
      hpps_gpio_cell u_cell (
        .clk(core_clk),
        .rst_b(rst_b),
        .mode(gpio_mode[gi]),
        .out_val(gpio_out_val[gi]),
        .pin_in(gpio_pin_in[gi]),
        .pin_o_q(gpio_pin_o_q[gi]),
        .pin_oe_n_q(gpio_pin_oe_n_q[gi]),
        .in_q(gpio_in_q[gi])
      );
    end
  endgenerate

  // Link side: sample data in on rising clock, present next data out bit
  always_comb begin
    lk_cnt_d = lk_cnt_q + hpps_pkg::BIT_STEP;
    lk_rx_d = {lk_rx_q[BYTE_W-2:0], data_in_or_addr_high_pin};
    if (lk_cnt_q == hpps_pkg::BIT_FIRST) begin
      lk_tx_d = {tx_hold_q[BYTE_W-2:0], 1'b0};
      lk_dout_d = tx_hold_q[BYTE_W-1];
    end else begin
      lk_tx_d = {lk_tx_q[BYTE_W-2:0], 1'b0};
      lk_dout_d = lk_tx_q[BYTE_W-1];
    end
    lk_byte_d = lk_byte_q;
    lk_tog_d = lk_tog_q;
    if (lk_cnt_q == hpps_pkg::BIT_LAST) begin
      lk_byte_d = lk_rx_d;
      lk_tog_d = ~lk_tog_q;
    end
  end

  // Clock may stop between frames, so the frame select clears this state
  always_ff @(posedge link_clk or posedge select_or_addr_low_pin) begin
    if (select_or_addr_low_pin) begin
      lk_cnt_q <= hpps_pkg::BIT_FIRST;
      lk_rx_q <= hpps_pkg::BYTE_ZERO;
      lk_tx_q <= hpps_pkg::BYTE_ZERO;
      dout_sda_o_q <= 1'b0;
    end else begin
      lk_cnt_q <= lk_cnt_d;
      lk_rx_q <= lk_rx_d;
      lk_tx_q <= lk_tx_d;
      dout_sda_o_q <= lk_dout_d;
    end
  end

  // Handed to core by toggle; byte stays put until the next byte ends
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      lk_byte_q <= hpps_pkg::BYTE_ZERO;
      lk_tog_q <= 1'b0;
    end else begin
      lk_byte_q <= lk_byte_d;
      lk_tog_q <= lk_tog_d;
    end
  end

  assign running = (st_q == hpps_pkg::HPPS_ST_RUN);

  // Core: start-up sequence, strap capture and pin steering
  always_comb begin
    st_d = st_q;
    wait_d = wait_q;
    mode_spi_d = mode_spi_q;
    i2c_addr_d = i2c_addr_q;
    osc_pll_run_d = 1'b1;
    unique case (st_q)
      hpps_pkg::HPPS_ST_HALT: begin
        wait_d = hpps_pkg::BIT_FIRST;
        st_d = hpps_pkg::HPPS_ST_STRAP;
      end
      hpps_pkg::HPPS_ST_STRAP: begin
        wait_d = wait_q + hpps_pkg::BIT_STEP;
        if (wait_q == hpps_pkg::STRAP_WAIT) begin
          // Straps read once per reset; later changes are ignored
          mode_spi_d = sy_lvl[hpps_pkg::SY_SEL];
          i2c_addr_d = {sy_lvl[hpps_pkg::SY_DIN], sy_lvl[hpps_pkg::SY_CS]};
          st_d = hpps_pkg::HPPS_ST_RUN;
        end
      end
      hpps_pkg::HPPS_ST_RUN: begin
        st_d = hpps_pkg::HPPS_ST_RUN;
      end
      default: begin
        st_d = hpps_pkg::HPPS_ST_HALT;
      end
    endcase

    spi_cs_active_d = running && mode_spi_q && !sy_lvl[hpps_pkg::SY_CS];

    // Transmit byte changes only outside a frame, so the link sees it stable
    tx_hold_d = tx_hold_q;
    if (!mode_spi_q) begin
      tx_hold_d = hpps_pkg::BYTE_ZERO;
    end else if (running && !spi_cs_active_q) begin
      tx_hold_d = spi_tx_byte;
    end

    ack_d = ack_q;
    spi_rx_byte_d = spi_rx_byte_q;
    spi_rx_valid_d = 1'b0;
    if (sy_lvl[hpps_pkg::SY_TOG] != ack_q) begin
      ack_d = sy_lvl[hpps_pkg::SY_TOG];
      if (running && mode_spi_q) begin
        spi_rx_byte_d = lk_byte_q;
        spi_rx_valid_d = 1'b1;
      end
    end

    if (!running) begin
      dout_sda_oe_n_d = 1'b1;
    end else if (mode_spi_q) begin
      dout_sda_oe_n_d = !spi_cs_active_q;
    end else begin
      dout_sda_oe_n_d = !i2c_sda_low;
    end

    // I2C view idles high in SPI mode
    i2c_scl_d = mode_spi_q ? 1'b1 : sy_lvl[hpps_pkg::SY_SCL];
    i2c_sda_d = mode_spi_q ? 1'b1 : sy_lvl[hpps_pkg::SY_SDA];

    irq_oe_n_d = !irq_pending;
    cts_active_d = !sy_lvl[hpps_pkg::SY_CTS];
    rts_n_d = !line_control_register[hpps_pkg::LCR_RTS_BIT];
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st_q <= hpps_pkg::HPPS_ST_HALT;
      wait_q <= hpps_pkg::BIT_FIRST;
      mode_spi_q <= 1'b0;
      i2c_addr_q <= 2'h0;
      ack_q <= 1'b0;
      tx_hold_q <= hpps_pkg::BYTE_ZERO;
      spi_rx_byte_q <= hpps_pkg::BYTE_ZERO;
      spi_rx_valid_q <= 1'b0;
      spi_cs_active_q <= 1'b0;
      dout_sda_oe_n_q <= 1'b1;
      i2c_scl_q <= 1'b1;
      i2c_sda_q <= 1'b1;
      irq_o_q <= 1'b0;
      irq_oe_n_q <= 1'b1;
      osc_pll_run_q <= 1'b0;
      cts_active_q <= 1'b0;
      request_send_output_n_q <= 1'b1;
    end else begin
      st_q <= st_d;
      wait_q <= wait_d;
      mode_spi_q <= mode_spi_d;
      i2c_addr_q <= i2c_addr_d;
      ack_q <= ack_d;
      tx_hold_q <= tx_hold_d;
      spi_rx_byte_q <= spi_rx_byte_d;
      spi_rx_valid_q <= spi_rx_valid_d;
      spi_cs_active_q <= spi_cs_active_d;
      dout_sda_oe_n_q <= dout_sda_oe_n_d;
      i2c_scl_q <= i2c_scl_d;
      i2c_sda_q <= i2c_sda_d;
      irq_o_q <= 1'b0;
      irq_oe_n_q <= irq_oe_n_d;
      osc_pll_run_q <= osc_pll_run_d;
      cts_active_q <= cts_active_d;
      request_send_output_n_q <= rts_n_d;
    end
  end

endmodule : hpps_pin_select

// File: hw/hpps_pkg.sv
// Purpose: Shared constants and types for the host port pin selector
// Assumes: Core clock at 10 MHz; link clock is the shared serial clock pin
// Notes: Indices name the slots of the pin synchroniser vector
package hpps_pkg;

  localparam int GPIO_N = 4;
  localparam int BYTE_W = 8;
  localparam int LCR_RTS_BIT = 7;
  localparam int CORE_CLK_KHZ = 10000;
  localparam int SPI_CLK_MAX_KHZ = 26000;
  localparam int I2C_CLK_MAX_KHZ = 400;

  // Synchroniser slots
  localparam int SY_SEL = 0;
  localparam int SY_CS = 1;
  localparam int SY_DIN = 2;
  localparam int SY_SCL = 3;
  localparam int SY_SDA = 4;
  localparam int SY_CTS = 5;
  localparam int SY_TOG = 6;
  localparam int SY_N = 7;
  // Idle levels: select, clock, data line and clear-to-send rest high
  localparam logic [SY_N-1:0] SY_RST = 7'h3a;

  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_STEP = 3'h1;
  // Covers three synchroniser stages plus the agree stage
  localparam logic [2:0] STRAP_WAIT = 3'h4;
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;

  typedef enum logic [1:0] {
    HPPS_GPIO_IN,
    HPPS_GPIO_PP,
    HPPS_GPIO_OD
  } hpps_gpio_mode_t;

  typedef enum logic [1:0] {
    HPPS_ST_HALT,
    HPPS_ST_STRAP,
    HPPS_ST_RUN
  } hpps_state_t;

endpackage : hpps_pkg

// File: hw/hpps_sync.sv
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Input is asynchronous to clk
// Notes: Output moves only when stages two and three agree
`timescale 1ns/100ps
module hpps_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Level in and filtered level out
  input wire logic pin,
  output logic level_q
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_d;

  always_comb begin
    level_d = (s2_q == s3_q) ? s3_q : level_q;
  end

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      level_q <= RST_VAL;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= level_d;
    end
  end

endmodule : hpps_sync

// File: hw/hpps_gpio_cell.sv
// Purpose: One general-purpose pin: input, push-pull or open-drain
// Assumes: Pad resolves level from output and active-low enable
// Notes: Pin has a weak pulldown, so the input rests low
`timescale 1ns/100ps
module hpps_gpio_cell (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Configuration
  input wire hpps_pkg::hpps_gpio_mode_t mode,
  input wire logic out_val,
  // Pad
  input wire logic pin_in,
  output logic pin_o_q,
  output logic pin_oe_n_q,
  // Sampled level
  output logic in_q
);

  logic pin_o_d;
  logic pin_oe_n_d;

  hpps_sync #(
    .RST_VAL(1'b0)
  ) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pin(pin_in),
    .level_q(in_q)
  );

  always_comb begin
    unique case (mode)
      hpps_pkg::HPPS_GPIO_IN: begin
        pin_o_d = 1'b0;
        pin_oe_n_d = 1'b1;
      end
      hpps_pkg::HPPS_GPIO_PP: begin
        pin_o_d = out_val;
        pin_oe_n_d = 1'b0;
      end
      hpps_pkg::HPPS_GPIO_OD: begin
        // Only ever pulls low; high is left to the pullup
        pin_o_d = 1'b0;
        pin_oe_n_d = out_val;
      end
      default: begin
        pin_o_d = 1'b0;
        pin_oe_n_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pin_o_q <= 1'b0;
      pin_oe_n_q <= 1'b1;
    end else begin
      pin_o_q <= pin_o_d;
      pin_oe_n_q <= pin_oe_n_d;
    end
  end

endmodule : hpps_gpio_cell

// File: dv/hpps_pin_select_props.sv
// Purpose: Port assertions for the host port pin selector
// Assumes: Straps static while running
// Notes: Attached by bind at the foot
`timescale 1ns/100ps
module hpps_props #(
  parameter int GPIO_N = 4,
  parameter int BYTE_W = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Host pins
  input wire logic select_or_addr_low_pin,
  input wire logic i2c_sda_low,
  input wire logic dout_sda_o_q,
  input wire logic dout_sda_oe_n_q,
  // Side pins
  input wire logic irq_pending,
  input wire logic irq_oe_n_q,
  input wire logic osc_pll_run_q,
  input wire hpps_pkg::hpps_gpio_mode_t [GPIO_N-1:0] gpio_mode,
  input wire logic [GPIO_N-1:0] gpio_out_val,
  input wire logic [GPIO_N-1:0] gpio_pin_o_q,
  input wire logic [GPIO_N-1:0] gpio_pin_oe_n_q,
  input wire logic [BYTE_W-1:0] line_control_register,
  input wire logic request_send_output_n_q,
  // Mode and link
  input wire logic mode_spi_q,
  input wire logic spi_rx_valid_q
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  a_irq_pin_follow: assert property (##1 irq_oe_n_q == !$past(irq_pending))
    else $error("irq pin does not follow pending");
  a_rts_from_lcr: assert property (##1 request_send_output_n_q == !$past(line_control_register[hpps_pkg::LCR_RTS_BIT]))
    else $error("rts pin wrong");
  // Must hold through reset, so no disable
  a_osc_halt_reset: assert property (disable iff (1'b0) ##1 osc_pll_run_q == $past(rst_b))
    else $error("oscillator run flag wrong");
  a_i2c_sda_pull: assert property (!mode_spi_q && i2c_sda_low |=> !dout_sda_oe_n_q && !dout_sda_o_q)
    else $error("data line not pulled low");
  a_spi_out_enable: assert property (mode_spi_q && $fell(select_or_addr_low_pin) |-> ##[3:6] !dout_sda_oe_n_q)
    else $error("data out not enabled");
  a_valid_one_cycle: assert property (spi_rx_valid_q |-> mode_spi_q ##1 !spi_rx_valid_q)
    else $error("byte valid wrong");
  a_gpio_push_pull: assert property (gpio_mode[0] == hpps_pkg::HPPS_GPIO_PP |=>
    !gpio_pin_oe_n_q[0] && gpio_pin_o_q[0] == $past(gpio_out_val[0]))
    else $error("push-pull drive wrong");
  a_gpio_open_drain: assert property (gpio_mode[0] == hpps_pkg::HPPS_GPIO_OD |=>
    !gpio_pin_o_q[0] && gpio_pin_oe_n_q[0] == $past(gpio_out_val[0]))
    else $error("open-drain drive wrong");
  c_spi_byte: cover property (spi_rx_valid_q);
  c_i2c_pull: cover property (!mode_spi_q && !dout_sda_oe_n_q);
  c_irq_low: cover property (!irq_oe_n_q);
endmodule : hpps_props

bind hpps_pin_select hpps_props #(.GPIO_N(GPIO_N), .BYTE_W(BYTE_W)) props_u (.*);

// File: dv/hpps_host_model.sv
// Purpose: SPI host model on the shared pins
// Assumes: Mode 0, device shifts out after the rise
// Notes: Clock stands low outside frames
`timescale 1ns/100ps
module hpps_host_model (
  // Link pins
  output logic clk,
  output logic sel_n,
  output logic din,
  // Data pin level
  input wire logic dout
);
  initial begin
    clk = 1'b0;
    sel_n = 1'b1;
    din = 1'b0;
  end
  task automatic frame(input logic [7:0] tx, output logic [7:0] rx);
    sel_n = 1'b0;
    // Lets the output enable cross before the first bit
    #800;
    for (int i = 7; i >= 0; i--) begin
      din = tx[i];
      #15 clk = 1'b1;
      #15 clk = 1'b0;
      rx[i] = dout;
    end
    #20 sel_n = 1'b1;
    din = ~din;
    // Gap keeps bytes apart in the core domain
    #1000;
  endtask : frame
endmodule : hpps_host_model

// File: dv/testbench.sv
// Purpose: Self-checking bench for the host port pin selector
// Assumes: Straps change around a reset, and once while running to check they are held
// Notes: Link clock comes from the host model in SPI mode and from scl_drv in I2C mode
`timescale 1ns/100ps
module testbench;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic host_spi_sel_pin = 1'b0;
  logic [1:0] strap = 2'h0;
  logic scl_drv = 1'b1;
  logic sda_ext = 1'b1;
  logic irq_pending = 1'b0;
  hpps_pkg::hpps_gpio_mode_t [3:0] gpio_mode = {4{hpps_pkg::HPPS_GPIO_IN}};
  logic [3:0] gpio_out_val = 4'h0;
  logic [3:0] gpio_pin_in = 4'h0;
  logic clear_send_n_pin = 1'b1;
  logic [7:0] line_control_register = 8'h00;
  logic [7:0] spi_tx_byte = 8'h00;
  logic i2c_sda_low = 1'b0;
  logic m_clk, m_sel, m_din, dout_sda_o_q, dout_sda_oe_n_q, irq_o_q, irq_oe_n_q;
  logic osc_pll_run_q, cts_active_q, request_send_output_n_q, mode_spi_q;
  logic spi_cs_active_q, spi_rx_valid_q, i2c_scl_q, i2c_sda_q;
  logic [1:0] i2c_addr_q;
  logic [3:0] gpio_pin_o_q, gpio_pin_oe_n_q, gpio_in_q;
  logic [7:0] spi_rx_byte_q;
  wire sclk_scl_pin = host_spi_sel_pin ? m_clk : scl_drv;
  wire link_clk = sclk_scl_pin;
  wire select_or_addr_low_pin = host_spi_sel_pin ? m_sel : strap[0];
  wire data_in_or_addr_high_pin = host_spi_sel_pin ? m_din : strap[1];
  // Open drain with pull-up; far party may also pull
  wire dout_sda_in = (dout_sda_oe_n_q | dout_sda_o_q) & sda_ext;
  int err_count = 0;
  int checks_done = 0;
  int pulses = 0;
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) if (spi_rx_valid_q === 1'b1) pulses <= pulses + 1;
  hpps_pin_select dut_u (.*);
  hpps_host_model m_u (.clk(m_clk), .sel_n(m_sel), .din(m_din), .dout(dout_sda_in));
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc
  task automatic do_reset(input logic s, input logic [1:0] st);
    @(posedge core_clk);
    rst_b <= 1'b0;
    host_spi_sel_pin <= s;
    strap <= st;
    cyc(19);
    chk("osc in reset", {7'h0, osc_pll_run_q}, 8'h00);
    @(posedge core_clk);
    rst_b <= 1'b1;
    cyc(10);
    chk("osc running", {7'h0, osc_pll_run_q}, 8'h01);
    chk("mode", {7'h0, mode_spi_q}, {7'h0, s});
  endtask : do_reset
  task automatic t_i2c();
    do_reset(1'b0, 2'h2);
    chk("addr straps", {6'h0, i2c_addr_q}, 8'h02);
    @(posedge core_clk);
    i2c_sda_low <= 1'b1;
    strap <= 2'h1;
    cyc(2);
    chk("sda drive", {6'h0, dout_sda_oe_n_q, dout_sda_o_q}, 8'h00);
    @(posedge core_clk);
    i2c_sda_low <= 1'b0;
    sda_ext <= 1'b0;
    scl_drv <= 1'b0;
    cyc(7);
    chk("sda release", {7'h0, dout_sda_oe_n_q}, 8'h01);
    chk("i2c pins", {6'h0, i2c_scl_q, i2c_sda_q}, 8'h00);
    chk("addr held", {6'h0, i2c_addr_q}, 8'h02);
    @(posedge core_clk);
    sda_ext <= 1'b1;
    scl_drv <= 1'b1;
    $display("test i2c done");
  endtask : t_i2c
  task automatic t_pins();
    chk("cts idle", {7'h0, cts_active_q}, 8'h00);
    for (int k = 0; k < 3; k++) begin
      @(posedge core_clk);
      gpio_mode <= {4{hpps_pkg::hpps_gpio_mode_t'(k)}};
      gpio_out_val <= 4'h6;
      cyc(2);
      chk("gpio oe_n", {4'h0, gpio_pin_oe_n_q}, k == 0 ? 8'h0f : k == 1 ? 8'h00 : 8'h06);
      if (k > 0) chk("gpio out", {4'h0, gpio_pin_o_q}, k == 1 ? 8'h06 : 8'h00);
    end
    @(posedge core_clk);
    gpio_mode <= {4{hpps_pkg::HPPS_GPIO_IN}};
    gpio_pin_in <= 4'h9;
    clear_send_n_pin <= 1'b0;
    irq_pending <= 1'b1;
    line_control_register <= 8'h80;
    cyc(2);
    chk("irq low", {6'h0, irq_oe_n_q, irq_o_q}, 8'h00);
    chk("rts low", {7'h0, request_send_output_n_q}, 8'h00);
    @(posedge core_clk);
    irq_pending <= 1'b0;
    line_control_register <= 8'h7f;
    cyc(6);
    chk("irq off", {7'h0, irq_oe_n_q}, 8'h01);
    chk("rts high", {7'h0, request_send_output_n_q}, 8'h01);
    chk("gpio in", {4'h0, gpio_in_q}, 8'h09);
    chk("cts", {7'h0, cts_active_q}, 8'h01);
    $display("test pins done");
  endtask : t_pins
  task automatic t_spi();
    logic [7:0] got;
    logic [7:0] pat [2] = '{8'h81, 8'h7e};
    do_reset(1'b1, 2'h0);
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk);
      spi_tx_byte <= ~pat[i];
      cyc(2);
      fork
        m_u.frame(pat[i], got);
        begin
          // Select has crossed well before the first link edge
          cyc(9);
          chk("cs active", {7'h0, spi_cs_active_q}, 8'h01);
          chk("dout enable", {7'h0, dout_sda_oe_n_q}, 8'h00);
        end
      join
      chk("dout byte", got, ~pat[i]);
      chk("din byte", spi_rx_byte_q, pat[i]);
      chk("byte pulses", pulses[7:0], i[7:0] + 8'h01);
    end
    $display("test spi done");
  endtask : t_spi
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude
  initial begin
    t_i2c();
    t_pins();
    t_spi();
    conclude();
  end
  // Tests need about 13 us; allow over ten times that
  initial begin
    #150000;
    err_count++;
    conclude();
  end
endmodule : testbench
